// ===== design/fsr_cfg_crc.sv
// Cyclic CRC check of the nonvolatile configuration bits.
// Assumes the bits and their reference CRC are stable levels.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"

module fsr_cfg_crc #(
    parameter int unsigned PERIOD_CYC = `FSR_CFG_CHECK_CYCLES
) (
    input  wire logic                       core_clk_i,  // 40 MHz clock
    input  wire logic                       rst_n_i,     // sync reset, low
    input  wire logic [`FSR_CFG_BITS_W-1:0] cfg_bits_i,  // configuration bits
    input  wire logic [`FSR_CRC_W-1:0]      cfg_crc_i,   // stored reference CRC
    output logic                            fault_o      // one-cycle mismatch pulse
);
    import fsr_pkg::*;

    typedef struct packed {
        logic [`FSR_CFG_CNT_W-1:0] cnt;
        logic                      fault;
    } fsr_crc_state_t;

    fsr_crc_state_t st_q, st_d;

    function automatic logic [`FSR_CRC_W-1:0] fsr_crc8(input logic [`FSR_CFG_BITS_W-1:0] d);
        logic [`FSR_CRC_W-1:0] c;
        c = `FSR_CRC_INIT;
        for (int i = `FSR_CFG_BITS_W - 1; i >= 0; i--) begin
            if (c[`FSR_CRC_W-1] ^ d[i]) begin
                c = {c[`FSR_CRC_W-2:0], 1'b0} ^ `FSR_CRC_POLY;
            end else begin
                c = {c[`FSR_CRC_W-2:0], 1'b0};
            end
        end
        return c;
    endfunction : fsr_crc8

    always_comb begin
        st_d       = st_q;
        st_d.fault = 1'b0;
        // (RL8) periodic config recheck
        if (st_q.cnt == `FSR_CFG_CNT_W'(PERIOD_CYC - 1)) begin
            st_d.cnt   = '0;
            st_d.fault = (fsr_crc8(cfg_bits_i) != cfg_crc_i);
        end else begin
            st_d.cnt = st_q.cnt + `FSR_CFG_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign fault_o = st_q.fault;

endmodule : fsr_cfg_crc
`default_nettype wire

// ===== design/fsr_defines.svh
// Register map, field positions, reset values and timing of the fail-safe status bank.
// Included by every design file of the bank; definitions only.
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

// Register indices on the fail-safe register port
`define FSR_ADDR_W             4
`define FSR_IDX_SAFE_IOS       4'h0
`define FSR_IDX_DIAG           4'h1
`define FSR_IDX_INT_MASK       4'h2
`define FSR_IDX_STATES         4'h3
`define FSR_IDX_OVUV           4'h4
`define FSR_IDX_INIT_BASE      4'h8
`define FSR_INIT_DEPTH         8
`define FSR_INIT_AW            3

// Data word spans bits 23 down to 8
`define FSR_DW_HI              23
`define FSR_DW_LO              8

// Safety pins status fields
`define FSR_BIT_RST_EVENT      17
`define FSR_BIT_RST_SHORT      16
`define FSR_BIT_RST_REQ        15
// Diagnostic fields
`define FSR_BIT_BUS_CRC        10
`define FSR_BIT_BUS_VIOL       9
`define FSR_DIAG_RSVD_ONES     16'h0081
// Interrupt mask fields
`define FSR_BIT_INH_AUX        14
`define FSR_BIT_INH_IO         13
`define FSR_BIT_INH_CORE       12
// State report fields
`define FSR_BIT_DBG_LEAVE      22
`define FSR_BIT_DBG_ACTIVE     21
`define FSR_BIT_CFG_CRC        19
`define FSR_BIT_INIT_MISMATCH  17
`define FSR_STATE_HI           12
`define FSR_STATE_LO           8
`define FSR_INIT_STATE_CODE    5'h06
// Monitor flag fields
`define FSR_BIT_CORE_OV        23
`define FSR_BIT_CORE_UV        22
`define FSR_BIT_IO_OV          21
`define FSR_BIT_IO_UV          20
`define FSR_BIT_AUX_OV         13
`define FSR_BIT_AUX_UV         12

// Reset values
`define FSR_RST_EVENT_INIT     1'b1
`define FSR_ZERO16             16'h0000
`define FSR_ONES16             16'hFFFF

// Configuration check
`define FSR_CLK_MHZ            40
`define FSR_CFG_PERIOD_US      5000
`define FSR_CFG_CHECK_CYCLES   (`FSR_CFG_PERIOD_US * `FSR_CLK_MHZ)
`define FSR_CFG_CNT_W          18
`define FSR_CFG_BITS_W         64
`define FSR_CRC_W              8
`define FSR_CRC_POLY           8'h07
`define FSR_CRC_INIT           8'hFF

`endif

// ===== design/fsr_init_mem.sv
// Init registers held twice: true value and bitwise complement copy.
// Two registered read ports: one for the host, one for the checker scan.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"

module fsr_init_mem (
    input  wire logic                          core_clk_i, // 40 MHz clock
    input  wire logic                          rst_n_i,    // sync reset, low
    input  wire logic                          wr_i,       // write strobe
    input  wire logic [`FSR_INIT_AW-1:0]       wr_addr_i,  // write index
    input  wire logic [`FSR_DW_HI:`FSR_DW_LO]  wr_data_i,  // write value
    input  wire logic [`FSR_INIT_AW-1:0]       rd_addr_i,  // host read index
    output logic      [`FSR_DW_HI:`FSR_DW_LO]  rd_data_o,  // host read value
    input  wire logic [`FSR_INIT_AW-1:0]       scan_addr_i,// scan index
    output logic      [`FSR_DW_HI:`FSR_DW_LO]  scan_val_o, // scanned value
    output logic      [`FSR_DW_HI:`FSR_DW_LO]  scan_inv_o  // scanned complement
);
    import fsr_pkg::*;

    typedef struct packed {
        logic [`FSR_INIT_DEPTH-1:0][15:0] val;
        logic [`FSR_INIT_DEPTH-1:0][15:0] inv;
        logic [15:0]                      rd;
        logic [15:0]                      sv;
        logic [15:0]                      si;
    } fsr_mem_state_t;

    fsr_mem_state_t st_q, st_d;

    always_comb begin
        st_d    = st_q;
        st_d.rd = st_q.val[rd_addr_i];
        st_d.sv = st_q.val[scan_addr_i];
        st_d.si = st_q.inv[scan_addr_i];
        if (wr_i) begin
            st_d.val[wr_addr_i] = wr_data_i;
            st_d.inv[wr_addr_i] = ~wr_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_q     <= '0;
            st_q.inv <= {`FSR_INIT_DEPTH{`FSR_ONES16}};
            st_q.si  <= `FSR_ONES16;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_o  = st_q.rd;
    assign scan_val_o = st_q.sv;
    assign scan_inv_o = st_q.si;

endmodule : fsr_init_mem
`default_nettype wire

// ===== design/fsr_pkg.sv
// Types shared by the fail-safe status bank.
// Field positions and constants live in fsr_defines.svh.
`include "fsr_defines.svh"

package fsr_pkg;

    // Register access from the fail-safe serial decoder
    typedef struct packed {
        logic                           wr;
        logic                           rd;
        logic [`FSR_ADDR_W-1:0]         addr;
        logic [`FSR_DW_HI:`FSR_DW_LO]   wdata;
    } fsr_req_t;

    // Event pulses from the rest of the device
    typedef struct packed {
        logic       reset_occurred;
        logic       reset_short_high;
        logic       bus_crc_err;
        logic       bus_bad_access;
        logic       debug_enter;
        logic [5:0] ovuv;    // core ov, core uv, io ov, io uv, aux ov, aux uv
    } fsr_evt_t;

endpackage : fsr_pkg

// ===== design/fsr_top.sv
// Fail-safe status, diagnostic, interrupt-mask and state registers.
// Assumes a serial-bus decoder presents one access per strobe, event inputs
// are one-cycle pulses synchronous to core_clk_i, and the state code is live.
//
// How it works
// (RL1) Reset-occurred flag, bit 17, set on any reset, cleared by writing 1.
// (RL2) Reset-output short-high flag, bit 16, sticky, cleared by writing 1.
// (RL3) Writing 1 to bit 15 sends one reset-output pulse; 0 does nothing.
// (RL4) Bus CRC error flag, bit 10, set on bad frame CRC, write-1-clear.
// (RL5) Access violation flag, bit 9, bad access, bad address or init write outside init state.
// (RL6) Bits 14, 13, 12 mask aux, io and core monitor interrupts; reset 0.
// (RL7) Writing 1 to bit 22 leaves debug mode; bit 21 shows debug live.
// (RL8) Config CRC rechecked every 5 ms; mismatch sets bit 19, write-1-clear.
// (RL9) Init registers compared against complement copies; mismatch flag sticky.
// (RL10) Bits 12 to 8 show the safety state code live; 0x06 is init.
// (RL11) Monitor overvoltage and undervoltage flags sticky, write-1-clear.
// (RL12) Writing 0 leaves flags; reserved bits ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"

module fsr_top #(
    parameter int unsigned CFG_CHECK_CYCLES = `FSR_CFG_CHECK_CYCLES
) (
    input  wire logic                          core_clk_i,               // 40 MHz clock
    input  wire logic                          rst_n_i,                  // sync reset, low
    input  wire fsr_pkg::fsr_req_t             req_i,                    // register access
    input  wire fsr_pkg::fsr_evt_t             evt_i,                    // event pulses
    input  wire logic [4:0]                    safety_state_code_i,      // live state code
    input  wire logic [`FSR_CFG_BITS_W-1:0]    config_bits_i,            // config bits
    input  wire logic [`FSR_CRC_W-1:0]         config_crc_i,             // config reference CRC
    output logic      [`FSR_DW_HI:`FSR_DW_LO]  reg_rdata_o,              // read data
    output logic                               reg_rvalid_o,             // read data valid
    output logic                               reset_pulse_request_o,    // reset pulse request
    output logic                               debug_leave_cmd_o,        // leave debug pulse
    output logic                               debug_active_status_o,    // in debug mode
    output logic                               interrupt_output_pin_n_o  // interrupt, low
);
    import fsr_pkg::*;

    typedef struct packed {
        logic                         reset_occurred_flag;
        logic                         reset_short_high_flag;
        logic                         safe_bus_crc_error;
        logic                         safe_bus_access_violation;
        logic                         aux_monitor_irq_inhibit;
        logic                         io_rail_irq_inhibit;
        logic                         core_monitor_irq_inhibit;
        logic                         debug_active;
        logic                         config_crc_fault;
        logic                         init_copy_mismatch;
        logic [5:0]                   ovuv;
        logic                         reset_pulse;
        logic                         debug_leave;
        logic                         irq;
        logic [`FSR_DW_HI:`FSR_DW_LO] rdata;
        logic                         rvalid;
        logic                         rd_mem;
        logic                         scan_valid;
        logic [`FSR_INIT_AW-1:0]      scan_idx;
    } fsr_state_t;

    fsr_state_t st_q, st_d;

    logic                         cfg_fault;
    logic [`FSR_DW_HI:`FSR_DW_LO] mem_rdata;
    logic [`FSR_DW_HI:`FSR_DW_LO] scan_val;
    logic [`FSR_DW_HI:`FSR_DW_LO] scan_inv;
    logic                         init_mode;
    logic                         init_wr;

    function automatic logic fsr_is_init(input logic [`FSR_ADDR_W-1:0] a);
        return a >= `FSR_IDX_INIT_BASE;
    endfunction : fsr_is_init

    function automatic logic fsr_is_mapped(input logic [`FSR_ADDR_W-1:0] a);
        return (a <= `FSR_IDX_OVUV) || fsr_is_init(a);
    endfunction : fsr_is_mapped

    function automatic logic fsr_w1(input fsr_req_t r, input logic [`FSR_ADDR_W-1:0] a,
                                    input int unsigned b);
        return r.wr && (r.addr == a) && r.wdata[b];
    endfunction : fsr_w1

    // (RL10) init state decode
    assign init_mode = (safety_state_code_i == `FSR_INIT_STATE_CODE);
    assign init_wr   = req_i.wr && fsr_is_init(req_i.addr) && init_mode;

    fsr_cfg_crc #(
        .PERIOD_CYC (CFG_CHECK_CYCLES)
    ) u_cfg_crc (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .cfg_bits_i (config_bits_i),
        .cfg_crc_i  (config_crc_i),
        .fault_o    (cfg_fault)
    );

    fsr_init_mem u_init_mem (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .wr_i        (init_wr),
        .wr_addr_i   (req_i.addr[`FSR_INIT_AW-1:0]),
        .wr_data_i   (req_i.wdata),
        .rd_addr_i   (req_i.addr[`FSR_INIT_AW-1:0]),
        .rd_data_o   (mem_rdata),
        .scan_addr_i (st_q.scan_idx),
        .scan_val_o  (scan_val),
        .scan_inv_o  (scan_inv)
    );

    always_comb begin
        st_d             = st_q;
        st_d.reset_pulse = 1'b0;
        st_d.debug_leave = 1'b0;
        st_d.rvalid      = 1'b0;

        // Clears first, sets after, so an event in the clear cycle survives
        // (RL1) reset-occurred flag
        if (fsr_w1(req_i, `FSR_IDX_SAFE_IOS, `FSR_BIT_RST_EVENT)) begin
            st_d.reset_occurred_flag = 1'b0;
        end
        if (evt_i.reset_occurred) begin
            st_d.reset_occurred_flag = 1'b1;
        end
        // (RL2) short-high flag
        if (fsr_w1(req_i, `FSR_IDX_SAFE_IOS, `FSR_BIT_RST_SHORT)) begin
            st_d.reset_short_high_flag = 1'b0;
        end
        if (evt_i.reset_short_high) begin
            st_d.reset_short_high_flag = 1'b1;
        end
        // (RL3) single reset pulse
        if (fsr_w1(req_i, `FSR_IDX_SAFE_IOS, `FSR_BIT_RST_REQ)) begin
            st_d.reset_pulse = 1'b1;
        end

        // (RL4) bus CRC error flag
        if (fsr_w1(req_i, `FSR_IDX_DIAG, `FSR_BIT_BUS_CRC)) begin
            st_d.safe_bus_crc_error = 1'b0;
        end
        if (evt_i.bus_crc_err) begin
            st_d.safe_bus_crc_error = 1'b1;
        end
        // (RL5) access violation sources
        if (fsr_w1(req_i, `FSR_IDX_DIAG, `FSR_BIT_BUS_VIOL)) begin
            st_d.safe_bus_access_violation = 1'b0;
        end
        if (evt_i.bus_bad_access
            || ((req_i.wr || req_i.rd) && !fsr_is_mapped(req_i.addr))
            || (req_i.wr && fsr_is_init(req_i.addr) && !init_mode)) begin
            st_d.safe_bus_access_violation = 1'b1;
        end

        // (RL6) inhibit bits, plain read/write
        if (req_i.wr && (req_i.addr == `FSR_IDX_INT_MASK)) begin
            st_d.aux_monitor_irq_inhibit  = req_i.wdata[`FSR_BIT_INH_AUX];
            st_d.io_rail_irq_inhibit      = req_i.wdata[`FSR_BIT_INH_IO];
            st_d.core_monitor_irq_inhibit = req_i.wdata[`FSR_BIT_INH_CORE];
        end

        // (RL7) leave debug on write 1
        if (fsr_w1(req_i, `FSR_IDX_STATES, `FSR_BIT_DBG_LEAVE)) begin
            st_d.debug_active = 1'b0;
            st_d.debug_leave  = 1'b1;
        end
        if (evt_i.debug_enter) begin
            st_d.debug_active = 1'b1;
        end
        // (RL8) config CRC fault flag
        if (fsr_w1(req_i, `FSR_IDX_STATES, `FSR_BIT_CFG_CRC)) begin
            st_d.config_crc_fault = 1'b0;
        end
        if (cfg_fault) begin
            st_d.config_crc_fault = 1'b1;
        end
        // (RL9) complement copy scan, one entry per cycle
        st_d.scan_idx   = st_q.scan_idx + `FSR_INIT_AW'(1);
        st_d.scan_valid = 1'b1;
        if (fsr_w1(req_i, `FSR_IDX_STATES, `FSR_BIT_INIT_MISMATCH)) begin
            st_d.init_copy_mismatch = 1'b0;
        end
        if (st_q.scan_valid && ((scan_val ^ scan_inv) != `FSR_ONES16)) begin
            st_d.init_copy_mismatch = 1'b1;
        end

        // (RL11) monitor flags, one write-1-clear per bit
        if (req_i.wr && (req_i.addr == `FSR_IDX_OVUV)) begin
            st_d.ovuv = st_q.ovuv & ~{req_i.wdata[`FSR_BIT_CORE_OV],
                                      req_i.wdata[`FSR_BIT_CORE_UV],
                                      req_i.wdata[`FSR_BIT_IO_OV],
                                      req_i.wdata[`FSR_BIT_IO_UV],
                                      req_i.wdata[`FSR_BIT_AUX_OV],
                                      req_i.wdata[`FSR_BIT_AUX_UV]};
        end
        st_d.ovuv = st_d.ovuv | evt_i.ovuv;

        // (RL6) masked interrupt, registered to keep the pin glitch free
        st_d.irq = (|st_q.ovuv[5:4] && !st_q.core_monitor_irq_inhibit)
                || (|st_q.ovuv[3:2] && !st_q.io_rail_irq_inhibit)
                || (|st_q.ovuv[1:0] && !st_q.aux_monitor_irq_inhibit);

        // (RL12) read mux; reserved positions read as constants
        if (req_i.rd) begin
            st_d.rvalid = 1'b1;
            st_d.rd_mem = fsr_is_init(req_i.addr);
            st_d.rdata  = `FSR_ZERO16;
            unique case (req_i.addr)
                `FSR_IDX_SAFE_IOS: begin
                    st_d.rdata[`FSR_BIT_RST_EVENT] = st_q.reset_occurred_flag;
                    st_d.rdata[`FSR_BIT_RST_SHORT] = st_q.reset_short_high_flag;
                end
                `FSR_IDX_DIAG: begin
                    st_d.rdata                    = `FSR_DIAG_RSVD_ONES;
                    st_d.rdata[`FSR_BIT_BUS_CRC]  = st_q.safe_bus_crc_error;
                    st_d.rdata[`FSR_BIT_BUS_VIOL] = st_q.safe_bus_access_violation;
                end
                `FSR_IDX_INT_MASK: begin
                    st_d.rdata[`FSR_BIT_INH_AUX]  = st_q.aux_monitor_irq_inhibit;
                    st_d.rdata[`FSR_BIT_INH_IO]   = st_q.io_rail_irq_inhibit;
                    st_d.rdata[`FSR_BIT_INH_CORE] = st_q.core_monitor_irq_inhibit;
                end
                `FSR_IDX_STATES: begin
                    st_d.rdata[`FSR_BIT_DBG_ACTIVE]    = st_q.debug_active;
                    st_d.rdata[`FSR_BIT_CFG_CRC]       = st_q.config_crc_fault;
                    st_d.rdata[`FSR_BIT_INIT_MISMATCH] = st_q.init_copy_mismatch;
                    // (RL10) live state code
                    st_d.rdata[`FSR_STATE_HI:`FSR_STATE_LO] = safety_state_code_i;
                end
                `FSR_IDX_OVUV: begin
                    st_d.rdata[`FSR_BIT_CORE_OV] = st_q.ovuv[5];
                    st_d.rdata[`FSR_BIT_CORE_UV] = st_q.ovuv[4];
                    st_d.rdata[`FSR_BIT_IO_OV]   = st_q.ovuv[3];
                    st_d.rdata[`FSR_BIT_IO_UV]   = st_q.ovuv[2];
                    st_d.rdata[`FSR_BIT_AUX_OV]  = st_q.ovuv[1];
                    st_d.rdata[`FSR_BIT_AUX_UV]  = st_q.ovuv[0];
                end
                default: begin
                    st_d.rdata = `FSR_ZERO16;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_q                     <= '0;
            // (RL1) power-on counts as a reset
            st_q.reset_occurred_flag <= `FSR_RST_EVENT_INIT;
        end else begin
            st_q <= st_d;
        end
    end

    // Init reads come straight from the memory's output register
    assign reg_rdata_o              = st_q.rd_mem ? mem_rdata : st_q.rdata;
    assign reg_rvalid_o             = st_q.rvalid;
    assign reset_pulse_request_o    = st_q.reset_pulse;
    assign debug_leave_cmd_o        = st_q.debug_leave;
    assign debug_active_status_o    = st_q.debug_active;
    assign interrupt_output_pin_n_o = ~st_q.irq;

endmodule : fsr_top
`default_nettype wire

// ===== tb/fsr_host.sv
// Host model: issues accesses on the fail-safe register port.
// Assumes one access at a time; each strobe lasts one clock.
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
    input  wire logic        core_clk_i, // bank clock
    output var fsr_pkg::fsr_req_t req_o, // access request
    input  wire logic [23:8] rdata_i,    // read data
    input  wire logic        rvalid_i    // read valid
);
    import fsr_pkg::*;
    initial req_o = '0;
    task automatic access(input logic w, input logic r, input logic [3:0] a,
                          input logic [23:8] d, output logic ok, output logic [23:8] q);
        @(posedge core_clk_i);
        req_o <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge core_clk_i);
        req_o <= '0;
        #1;
        ok = rvalid_i;
        q = rdata_i;
    endtask : access
endmodule : fsr_host
`default_nettype wire

// ===== tb/fsr_top_properties.sv
// Port assertions of the fail-safe status bank.
// Bound into fsr_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"
module fsr_top_chk #(
    parameter int unsigned CFG_CHECK_CYCLES = `FSR_CFG_CHECK_CYCLES
) (
    input wire logic              core_clk_i,
    input wire logic              rst_n_i,
    input wire fsr_pkg::fsr_req_t req_i,
    input wire fsr_pkg::fsr_evt_t evt_i,
    input wire logic [4:0]        safety_state_code_i,
    input wire logic [23:8]       reg_rdata_o,
    input wire logic              reset_pulse_request_o,
    input wire logic              debug_leave_cmd_o,
    input wire logic              debug_active_status_o,
    input wire logic              interrupt_output_pin_n_o
);
    import fsr_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_pulse;
        req_i.wr && req_i.addr == 4'h0 && req_i.wdata[15] |=> reset_pulse_request_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("no reset pulse");
    property p_pulse_cause;
        reset_pulse_request_o |-> $past(req_i.wr && req_i.addr == 4'h0 && req_i.wdata[15]);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("stray reset pulse");
    property p_leave;
        req_i.wr && req_i.addr == 4'h3 && req_i.wdata[22] |=> debug_leave_cmd_o;
    endproperty
    a_leave: assert property (p_leave) else $error("no leave pulse");
    property p_enter;
        evt_i.debug_enter |=> debug_active_status_o;
    endproperty
    a_enter: assert property (p_enter) else $error("debug not set");
    property p_state;
        req_i.rd && req_i.addr == 4'h3 |=> reg_rdata_o[12:8] == $past(safety_state_code_i);
    endproperty
    a_state: assert property (p_state) else $error("state code not live");
    property p_diag;
        req_i.rd && req_i.addr == 4'h1 |=> reg_rdata_o[23:16] == 8'h00 && reg_rdata_o[15]
            && reg_rdata_o[8];
    endproperty
    a_diag: assert property (p_diag) else $error("diag reserved bits");
    property p_unmapped;
        req_i.rd && req_i.addr inside {4'h5, 4'h6, 4'h7} |=> reg_rdata_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_irq;
        $fell(interrupt_output_pin_n_o) |-> $past(evt_i.ovuv != 6'h00, 2) || $past(req_i.wr, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("stray interrupt");
endmodule : fsr_top_chk
bind fsr_top fsr_top_chk #(.CFG_CHECK_CYCLES(CFG_CHECK_CYCLES)) i_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .evt_i(evt_i),
    .safety_state_code_i(safety_state_code_i), .reg_rdata_o(reg_rdata_o),
    .reset_pulse_request_o(reset_pulse_request_o), .debug_leave_cmd_o(debug_leave_cmd_o),
    .debug_active_status_o(debug_active_status_o),
    .interrupt_output_pin_n_o(interrupt_output_pin_n_o));
`default_nettype wire

// ===== tb/test_failsafe_status_regs.sv
// Self-checking bench of the fail-safe status bank.
// Host accesses go through fsr_host; events and levels driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH %0t %s", $time, m); end end
module test_failsafe_status_regs;
    import fsr_pkg::*;
    localparam int unsigned CYC = 64;
    logic core_clk = 1'b0, rst_n = 1'b0, rv, pulse, leave, dbg, irq_n;
    fsr_req_t req;
    fsr_evt_t evt = '0, t;
    logic [4:0] state = 5'h00;
    logic [63:0] cfg_bits = 64'h0123_4567_89AB_CDEF;
    logic [7:0] cfg_crc, good;
    logic [23:8] rdata;
    int error_cnt = 0, tests_run = 0, seed = 57, e[5], im[8], dbg_m, k, v, g, m;
    always #12.5 core_clk = ~core_clk;
    fsr_top #(.CFG_CHECK_CYCLES(CYC)) i_dut (.core_clk_i(core_clk), .rst_n_i(rst_n),
        .req_i(req), .evt_i(evt), .safety_state_code_i(state), .config_bits_i(cfg_bits),
        .config_crc_i(cfg_crc), .reg_rdata_o(rdata), .reg_rvalid_o(rv),
        .reset_pulse_request_o(pulse), .debug_leave_cmd_o(leave),
        .debug_active_status_o(dbg), .interrupt_output_pin_n_o(irq_n));
    fsr_host i_host (.core_clk_i(core_clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rv));
    function automatic logic [7:0] crc8(input logic [63:0] b);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 63; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8
    task automatic model_reset();
        e = '{32'h2_0000, 32'h8100, 0, 0, 0};
        im = '{default: 0};
        dbg_m = 0;
    endtask : model_reset
    task automatic wr(input int a, input int d);
        logic ok;
        logic [23:8] q;
        i_host.access(1'b1, 1'b0, a[3:0], d[23:8], ok, q);
        case (a)
            0: e[0] &= ~(d & 32'h3_0000);
            1: e[1] &= ~(d & 32'h600);
            2: e[2] = d & 32'h7000;
            3: begin
                if (d[22]) dbg_m = 0;
                e[3] &= ~(d & 32'hA_0000);
            end
            4: e[4] &= ~(d & 32'hF0_3000);
            5, 6, 7: e[1] |= 32'h200;
            default: if (state == 5'h06) im[a-8] = d & 32'hFF_FF00; else e[1] |= 32'h200;
        endcase
    endtask : wr
    task automatic rd(input int a);
        logic ok;
        logic [23:8] q;
        int x;
        i_host.access(1'b0, 1'b1, a[3:0], 16'h0000, ok, q);
        x = (a >= 8) ? im[a-8] : (a == 3) ? (e[3] | (dbg_m << 21) | (state << 8))
            : (a < 5) ? e[a] : 0;
        `CHK(ok, 1'b1, "no answer")
        `CHK(q, x[23:8], "read data")
        if (a > 4 && a < 8) e[1] |= 32'h200;
    endtask : rd
    task automatic ev(input fsr_evt_t x);
        @(posedge core_clk);
        evt <= x;
        @(posedge core_clk);
        evt <= '0;
        e[0] |= (x.reset_occurred << 17) | (x.reset_short_high << 16);
        e[1] |= (x.bus_crc_err << 10) | (x.bus_bad_access << 9);
        e[4] |= (x.ovuv[5:2] << 20) | (x.ovuv[1:0] << 12);
        if (x.debug_enter) dbg_m = 1;
    endtask : ev
    task automatic settle();
        logic act;
        repeat (2) @(posedge core_clk);
        #1;
        act = ((e[4] & 32'hC0_0000) != 0 && !e[2][12]) || ((e[4] & 32'h30_0000) != 0
            && !e[2][13]) || ((e[4] & 32'h3000) != 0 && !e[2][14]);
        `CHK(irq_n, !act, "interrupt pin")
        `CHK(dbg, dbg_m[0], "debug")
    endtask : settle
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        good = crc8(cfg_bits);
        cfg_crc = good;
        model_reset();
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        for (k = 0; k < 5; k++) rd(k);
        t = '0;
        {t.reset_short_high, t.bus_crc_err, t.bus_bad_access} = 3'b111;
        ev(t);
        wr(0, 0);
        wr(1, 0);
        rd(0);
        rd(1);
        wr(0, 32'h3_0000);
        wr(1, 32'h600);
        rd(0);
        rd(1);
        wr(0, 0);
        `CHK(pulse, 1'b0, "pulse on zero")
        wr(0, 32'h8000);
        `CHK(pulse, 1'b1, "no pulse")
        @(posedge core_clk);
        #1;
        `CHK(pulse, 1'b0, "pulse too long")
        for (k = 0; k < 9; k++) begin
            g = k % 3;
            m = 32'h4000 >> g;
            wr(2, k < 3 ? m : k < 6 ? 32'h7000 ^ m : $random(seed) & 32'h7000);
            v = $random(seed);
            t = '0;
            t.ovuv[2 * (2 - g) + v[0]] = 1'b1;
            ev(t);
            settle();
            rd(2);
            rd(4);
            wr(4, 32'hF0_3000);
            settle();
        end
        t = '{debug_enter: 1'b1, reset_occurred: 1'b1, default: 0};
        ev(t);
        rd(0);
        wr(3, 0);
        settle();
        wr(3, 32'h40_0000);
        `CHK(leave, 1'b1, "no leave pulse")
        settle();
        rd(3);
        for (k = 5; k < 8; k++) begin
            wr(1, 32'h200);
            rd(k);
            rd(1);
        end
        wr(1, 32'h200);
        for (k = 0; k < 16; k++) begin
            v = $random(seed);
            @(posedge core_clk);
            state <= (k < 8) ? 5'h06 : (v[4:0] == 5'h06) ? 5'h07 : v[4:0];
            wr(8 + k % 8, v);
            rd(8 + k % 8);
            rd(1);
            rd(3);
        end
        repeat (3 * CYC) @(posedge core_clk);
        rd(3);
        cfg_crc <= good ^ 8'h01;
        repeat (2 * CYC + 4) @(posedge core_clk);
        cfg_crc <= good;
        e[3] |= 32'h8_0000;
        rd(3);
        repeat (CYC + 4) @(posedge core_clk);
        wr(3, 32'h8_0000);
        rd(3);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        model_reset();
        for (k = 0; k < 5; k++) rd(k);
        final_report();
    end
    initial begin
        repeat (6000) @(posedge core_clk);
        error_cnt++;
        final_report();
    end
endmodule : test_failsafe_status_regs
`default_nettype wire
